// File: tec_pkg.sv
// Package: constants and types for the 8-bit timer/event counter
package tec_pkg;
    localparam logic [7:0] TEC_ADDR_COUNTER = 8'h0D;
    localparam logic [7:0] TEC_ADDR_CONTROL = 8'h0E;
    localparam logic [7:0] TEC_ADDR_IRQ = 8'h0F;
    localparam logic [7:0] TEC_CONTROL_RESET = 8'h08;
    localparam logic [7:0] TEC_CONTROL_RMASK = 8'hDF;
    localparam int TEC_POS_PRESCALE = 0;
    localparam int TEC_POS_EDGE = 3;
    localparam int TEC_POS_RUN = 4;
    localparam int TEC_POS_MODE = 6;
    localparam int TEC_POS_FLAG = 5;
    localparam int TEC_POS_IRQEN = 0;
    localparam logic [7:0] TEC_COUNT_MAX = 8'hFF;
    localparam logic [1:0] TEC_MODE_UNUSED = 2'h0;
    localparam logic [1:0] TEC_MODE_EVENT = 2'h1;
    localparam logic [1:0] TEC_MODE_TIMER = 2'h2;
    localparam logic [1:0] TEC_MODE_PULSE = 2'h3;

    typedef struct packed {
        logic [1:0] mode;
        logic spare;
        logic run;
        logic edgeSel;
        logic [2:0] prescaleSel;
    } tec_ctrl_t;

    typedef enum logic [1:0] {
        TEC_PW_IDLE,
        TEC_PW_COUNT,
        TEC_PW_DONE
    } tec_pw_t;
endpackage

// File: tec_sync.sv
// Two-flop synchroniser for the counter input pin
`timescale 1ns/100ps
module tec_sync import tec_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic pinIn,
    output logic pinSync
);
    logic meta_ff;
    logic sync_ff;
    logic nxt_meta;
    logic nxt_sync;

    always_comb begin
        nxt_meta = pinIn;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign pinSync = sync_ff;
endmodule

// File: tec_prescaler.sv
// Free-running 7-stage prescaler giving a one-cycle tick at system_clk/2^n
`timescale 1ns/100ps
module tec_prescaler import tec_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic [2:0] prescaleSel,
    output logic tick
);
    logic [6:0] div_ff;
    logic [6:0] nxt_div;
    logic [6:0] mask;

    always_comb begin
        nxt_div = div_ff + 7'h01;
        mask = 7'(({7'h00, 1'b1} << prescaleSel) - 8'h01);
        // Tick when the low n bits have all wrapped to zero
        tick = ((div_ff & mask) == 7'h00);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_ff <= 7'h00;
        end else begin
            div_ff <= nxt_div;
        end
    end
endmodule

// File: tec_counter.sv
// Top level of the 8-bit timer/event counter with register port
`timescale 1ns/100ps
module tec_counter import tec_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic countInputPin,
    input wire logic irqAck,
    output logic overflowReqFlag,
    output logic overflowIrq,
    output logic overflowPulse,
    output logic wakeUp,
    output logic toneOut
);
    // ***************************************************************
    // Input conditioning
    // ***************************************************************
    logic pinSync;
    logic pinPrev_ff;
    logic prescaleTick;
    logic pinRise;
    logic pinFall;
    logic activeEdge;

    tec_ctrl_t ctrl_ff;
    tec_ctrl_t nxt_ctrl;

    tec_sync u_sync (
        .clk(clk),
        .reset(reset),
        .pinIn(countInputPin),
        .pinSync(pinSync)
    );

    tec_prescaler u_prescaler (
        .clk(clk),
        .reset(reset),
        .prescaleSel(ctrl_ff.prescaleSel),
        .tick(prescaleTick)
    );

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pinPrev_ff <= 1'b0;
        end else begin
            pinPrev_ff <= pinSync;
        end
    end

    assign pinRise = pinSync & ~pinPrev_ff;
    assign pinFall = ~pinSync & pinPrev_ff;
    // Edge bit 0 selects rising, 1 falling, in event and pulse modes
    function automatic logic pickEdge(input logic sel, input logic rise,
            input logic fall);
        pickEdge = sel ? fall : rise;
    endfunction

    assign activeEdge = pickEdge(ctrl_ff.edgeSel, pinRise,
        pinFall);

    // ***************************************************************
    // Register decode
    // ***************************************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    logic wrCounter;
    logic wrControl;
    logic wrIrq;
    logic rdCounter;

    assign wrCounter = regWrite & hit(regAddr, TEC_ADDR_COUNTER);
    assign wrControl = regWrite & hit(regAddr, TEC_ADDR_CONTROL);
    assign wrIrq = regWrite & hit(regAddr, TEC_ADDR_IRQ);
    assign rdCounter = regRead & hit(regAddr, TEC_ADDR_COUNTER);

    // ***************************************************************
    // Counter core
    // ***************************************************************
    logic [7:0] count_ff;
    logic [7:0] preload_ff;
    logic flag_ff;
    logic irqEn_ff;
    logic tone_ff;
    logic [7:0] rdata_ff;
    tec_pw_t pw_ff;

    logic [7:0] nxt_count;
    logic [7:0] nxt_preload;
    logic nxt_flag;
    logic nxt_irqEn;
    logic nxt_tone;
    logic [7:0] nxt_rdata;
    tec_pw_t nxt_pw;
    logic countTick;
    logic overflow;
    logic pwEnd;

    always_comb begin
        countTick = 1'b0;
        pwEnd = 1'b0;
        nxt_pw = pw_ff;
        case (ctrl_ff.mode)
            TEC_MODE_EVENT: begin
                countTick = activeEdge;
            end
            TEC_MODE_TIMER: begin
                countTick = prescaleTick;
            end
            TEC_MODE_PULSE: begin
                case (pw_ff)
                    TEC_PW_IDLE: begin
                        // Only a transition arms the measurement
                        if (ctrl_ff.run && activeEdge) begin
                            nxt_pw = TEC_PW_COUNT;
                        end
                    end
                    TEC_PW_COUNT: begin
                        // Return to former level ends the pulse
                        if (pickEdge(ctrl_ff.edgeSel, pinFall, pinRise)) begin
                            pwEnd = 1'b1;
                            nxt_pw = TEC_PW_DONE;
                        end else begin
                            countTick = prescaleTick;
                        end
                    end
                    TEC_PW_DONE: begin
                        // Result held until software sets run again
                        if (ctrl_ff.run) begin
                            nxt_pw = TEC_PW_IDLE;
                        end
                    end
                    default: begin
                        nxt_pw = TEC_PW_IDLE;
                    end
                endcase
            end
            default: begin
                countTick = 1'b0;
            end
        endcase
        if (ctrl_ff.mode != TEC_MODE_PULSE) begin
            nxt_pw = TEC_PW_IDLE;
        end
        // Reading freezes the count; an event in that cycle is lost
        countTick = countTick & ctrl_ff.run & ~rdCounter;
        overflow = countTick && (count_ff == TEC_COUNT_MAX);
    end

    // ***************************************************************
    // Count, preload and tone
    // ***************************************************************
    always_comb begin
        nxt_count = count_ff;
        nxt_preload = preload_ff;
        nxt_tone = tone_ff;
        if (overflow) begin
            nxt_count = preload_ff;
            nxt_tone = ~tone_ff;
        end else if (countTick) begin
            nxt_count = count_ff + 8'h01;
        end
        if (wrCounter) begin
            nxt_preload = regWdata;
            // A stopped counter takes the new start value at once
            if (!ctrl_ff.run) begin
                nxt_count = regWdata;
            end
        end
    end

    // Count is undefined after reset; zero keeps readback clean
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_ff <= 8'h00;
            preload_ff <= 8'h00;
            tone_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            preload_ff <= nxt_preload;
            tone_ff <= nxt_tone;
        end
    end

    // ***************************************************************
    // Control register and pulse measurement state
    // ***************************************************************
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (pwEnd) begin
            nxt_ctrl.run = 1'b0;
        end
        // A software write wins over the hardware clear of run
        if (wrControl) begin
            nxt_ctrl = tec_ctrl_t'(regWdata & TEC_CONTROL_RMASK);
        end
    end

    // Only hard reset loads TEC_CONTROL_RESET into this block
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_ff <= tec_ctrl_t'(TEC_CONTROL_RESET);
            pw_ff <= TEC_PW_IDLE;
        end else begin
            ctrl_ff <= nxt_ctrl;
            pw_ff <= nxt_pw;
        end
    end

    // ***************************************************************
    // Overflow flag and interrupt enable
    // ***************************************************************
    always_comb begin
        nxt_flag = flag_ff;
        nxt_irqEn = irqEn_ff;
        if (wrIrq) begin
            nxt_flag = regWdata[TEC_POS_FLAG];
            nxt_irqEn = regWdata[TEC_POS_IRQEN];
        end else if (irqAck) begin
            nxt_flag = 1'b0;
        end
        // Set wins over any clear; repeats while set merge
        if (overflow) begin
            nxt_flag = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flag_ff <= 1'b0;
            irqEn_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
            irqEn_ff <= nxt_irqEn;
        end
    end

    // ***************************************************************
    // Register readback
    // ***************************************************************
    // Data stand for one cycle only, zero otherwise
    always_comb begin
        nxt_rdata = 8'h00;
        if (regRead) begin
            if (hit(regAddr, TEC_ADDR_COUNTER)) begin
                nxt_rdata = count_ff;
            end else if (hit(regAddr, TEC_ADDR_CONTROL)) begin
                nxt_rdata = 8'(ctrl_ff) & TEC_CONTROL_RMASK;
            end else if (hit(regAddr, TEC_ADDR_IRQ)) begin
                nxt_rdata = 8'h00;
                nxt_rdata[TEC_POS_FLAG] = flag_ff;
                nxt_rdata[TEC_POS_IRQEN] = irqEn_ff;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    logic ovf_ff;
    logic nxt_ovf;

    always_comb begin
        nxt_ovf = overflow;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ovf_ff <= 1'b0;
        end else begin
            ovf_ff <= nxt_ovf;
        end
    end

    assign regRdata = rdata_ff;
    assign overflowReqFlag = flag_ff;
    assign overflowIrq = flag_ff & irqEn_ff;
    assign overflowPulse = ovf_ff;
    assign wakeUp = ovf_ff;
    assign toneOut = tone_ff;
endmodule

// File: tec_counter_checker.sv
// Port assertions for the timer/event counter
`timescale 1ns/100ps
module tec_counter_checker import tec_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    input wire logic countInputPin,
    input wire logic irqAck,
    input wire logic overflowReqFlag,
    input wire logic overflowIrq,
    input wire logic overflowPulse,
    input wire logic wakeUp,
    input wire logic toneOut
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // ****************
    // Output relations
    // ****************
    a_wake_pulse: assert property (
        wakeUp |-> $changed(toneOut)) else $error("wake without overflow");
    a_tone_pulse: assert property (
        $changed(toneOut) |-> overflowPulse) else $error("tone no pulse");
    a_tone_flag: assert property (
        $changed(toneOut) |-> overflowReqFlag) else $error("tone no flag");
    a_irq_gate: assert property (
        overflowIrq |-> overflowReqFlag) else $error("irq no flag");
    a_rdata_idle: assert property (
        !$past(regRead) |-> regRdata == 8'h00) else $error("stray data");
    a_spare_zero: assert property (
        $past(regRead && regAddr == TEC_ADDR_CONTROL) |-> !regRdata[5])
        else $error("spare bit set");
    a_flag_sticky: assert property (
        overflowReqFlag && !irqAck && !(regWrite && regAddr == TEC_ADDR_IRQ)
        |=> overflowReqFlag) else $error("flag lost");
    a_unmapped_zero: assert property (
        $past(regRead && (regAddr < 8'h0D || regAddr > 8'h0F))
        |-> regRdata == 8'h00) else $error("unmapped data");
endmodule

bind tec_counter tec_counter_checker chk0 (.clk(clk), .reset(reset),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .countInputPin(countInputPin),
    .irqAck(irqAck), .overflowReqFlag(overflowReqFlag),
    .overflowIrq(overflowIrq), .overflowPulse(overflowPulse),
    .wakeUp(wakeUp), .toneOut(toneOut));

// File: tec_pin_model.sv
// External pulse source on the counter input pin
`timescale 1ns/100ps
module tec_pin_model (
    input wire logic clk,
    input wire logic fire,
    input wire logic [7:0] width,
    input wire logic idleLvl,
    output logic pin
);
    logic [7:0] left_ff = 8'h00;
    // Pin rests at idleLvl; a fire drives the opposite level for width cycles
    always @(posedge clk)
        left_ff <= fire ? width : left_ff - 8'(left_ff != 8'h00);
    assign pin = (left_ff != 8'h00) ? !idleLvl : idleLvl;
endmodule

// File: test_tec_counter.sv
// Testbench for the timer/event counter
`timescale 1ns/100ps
module test_tec_counter import tec_pkg::*;;
    logic clk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic irqAck = 1'b0, fire = 1'b0, idleLvl = 1'b0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, rd, keep;
    logic pin, flag, irq, ovf, tone, wake;
    int miscompares = 0, comparisons = 0, n, c;

    always #4 clk = ~clk;

    tec_counter dut (.clk(clk), .reset(reset), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .countInputPin(pin), .irqAck(irqAck),
        .overflowReqFlag(flag), .overflowIrq(irq), .overflowPulse(ovf),
        .wakeUp(wake), .toneOut(tone));
    tec_pin_model pinModel (.clk(clk), .fire(fire), .width(8'h14),
        .idleLvl(idleLvl), .pin(pin));

    // ****************
    // Access tasks
    // ****************
    task automatic test_done();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rdReg(input logic [7:0] a);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 rd = regRdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        rdReg(a);
        chk(rd, e);
    endtask
    task automatic waitOvf();
        c = 0;
        do begin
            @(posedge clk);
            #1 c++;
        end while (ovf !== 1'b1 && c < 9000);
        if (c >= 9000) begin
            miscompares++;
            test_done();
        end else begin
            chk(wake, 1'b1);
        end
    endtask
    task automatic pulse(input int gap);
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (gap) @(posedge clk);
    endtask

    // ****************
    // Scenarios
    // ****************
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rdc(8'h0E, TEC_CONTROL_RESET);
        rdc(8'h3A, 8'h00);
        wr(8'h0E, 8'hFF);
        rdc(8'h0E, 8'hDF);
        wr(8'h0E, 8'h00);
        wr(8'h0D, 8'hF0);
        rdc(8'h0D, 8'hF0);
        wr(8'h0F, 8'h01);
        for (n = 0; n < 8; n++) begin
            wr(8'h0E, 8'h90 | 8'(n));
            waitOvf();
            chk(tone, 1'b1);
            waitOvf();
            chk(16'(c), 16'(16 << n));
        end
        chk(irq, 1'b1);
        wr(8'h0F, 8'h00);
        waitOvf();
        chk({flag, irq}, 2'h2);
        @(posedge clk);
        irqAck <= 1'b1;
        @(posedge clk);
        irqAck <= 1'b0;
        #1 chk(flag, 1'b0);
        wr(8'h0D, 8'h10);
        rdReg(8'h0D);
        chk(rd[7:4], 4'hF);
        waitOvf();
        rdc(8'h0D, 8'h10);
        // Back-to-back reads at full rate must freeze the count
        wr(8'h0E, 8'h90);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= 8'h0D;
        @(posedge clk);
        #1 keep = regRdata;
        repeat (5) begin
            @(posedge clk);
            #1 chk(regRdata, keep);
        end
        @(posedge clk);
        regRead <= 1'b0;
        for (n = 0; n < 2; n++) begin
            wr(8'h0E, 8'h00);
            wr(8'h0D, 8'h00);
            wr(8'h0E, 8'h50 | 8'(n << 3));
            pulse(10);
            rdc(8'h0D, 8'(n == 0));
            // Let the first pulse end so the second gives fresh edges
            repeat (10) @(posedge clk);
            pulse(30);
            rdc(8'h0D, 8'h02);
        end
        wr(8'h0E, 8'h00);
        wr(8'h0D, 8'h00);
        wr(8'h0E, 8'hD0);
        pulse(30);
        rdReg(8'h0D);
        keep = rd;
        chk(16'(rd > 8'h12 && rd < 8'h16), 16'h0001);
        rdc(8'h0E, 8'hC0);
        pulse(30);
        rdc(8'h0D, keep);
        // Overflow while measuring reloads from preload, not from zero
        wr(8'h0F, 8'h00);
        wr(8'h0D, 8'hF0);
        wr(8'h0E, 8'hD0);
        pulse(30);
        chk(flag, 1'b1);
        rdReg(8'h0D);
        keep = rd;
        chk(rd[7:4], 4'hF);
        // Let the pin settle high before arming so no edge is seen
        @(posedge clk);
        idleLvl <= 1'b1;
        repeat (6) @(posedge clk);
        wr(8'h0E, 8'hD0);
        repeat (10) @(posedge clk);
        rdc(8'h0D, keep);
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        rdc(8'h0E, TEC_CONTROL_RESET);
        test_done();
    end
endmodule
